// ---- logic/adc_single_ctrl.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Bits b0,b2 pick trigger: in bus 2, in bus 3, out bus 3, timer edge.
// - Trigger choice is ignored while software start is selected.
// - In comparator mode hardware triggers are ignored; software start only.
// - Bit b3 chooses software start bit or hardware trigger as source.
// - Completion raises interrupt request (b4=0) or DMA request (b4=1).
// - Done flag b5 reads 1 after reset, 0 while running, 1 when done.
// - A stop of a running operation also sets the done flag.
// - Stop b6 halts single mode at once; ignored when idle or scan-only.
// - After stop the SAR keeps its partial value; no result is stored.
// - Start and stop written together: stop acts, start is ignored.
// - Stop during a forced single ends it and lets scan resume.
// - Start b7 launches conversion with software start selected or in comparator mode.
// - Start while running abandons and restarts the single conversion.
// - Start during scan cancels scan channel; scan resumes from it after.
// - Stop and start act on 1 only and always read back 0.
// - Bit b8 chooses conversion (0) or comparator mode (1).
// - Bit b9 selects normal or double conversion speed.
// - Bit b10 enables sample-and-hold; no effect in comparator mode.
// - Bit b11 selects fast sample-and-hold; ignored when it is off.
// - Bits b12-b15 pick channel 0 to 15 and read back as written.
// - Effective speed comes from speed, hold bits and global speed bit.
// - Results go to the channel data register, compares to their own.
module adc_single_ctrl #(
   parameter int NUM_CH = 16,
   parameter int RES_W = 10
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire adc_single_pkg::av_req_t bus_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire adc_single_pkg::trig_evt_t trig_i,
   input wire logic scan_active_i,
   input wire logic conv_done_i,
   input wire logic [RES_W-1:0] conv_result_i,
   input wire logic [RES_W-1:0] conv_sar_i,
   output adc_single_pkg::conv_cmd_t conv_o,
   output logic scan_hold_o,
   output logic irq_req_o,
   output logic dma_req_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      adc_single_pkg::mode_st_t st;
      logic [7:0] sim0;
      logic [7:0] sim1;
      logic [7:0] scm0;
      logic gspd;
      logic [RES_W-1:0] sar;
      logic [RES_W-1:0] cmp_result;
      logic [NUM_CH-1:0][RES_W-1:0] result;
      logic ack;
      logic [31:0] rdata;
      adc_single_pkg::conv_cmd_t conv;
      logic irq;
      logic dma;
   } state_t;

   state_t s;
   state_t next_s;

   logic req;
   logic wr;
   logic lane0;
   logic [31:0] data_off;
   logic data_hit;
   logic [3:0] data_idx;
   logic [7:0] sim0_rd;
   logic [7:0] sim0_now;
   logic cmp_now;
   logic sw_start;
   logic sw_stop;
   logic sar_start;
   logic hw_evt;
   logic start_req;
   logic busy;
   logic stop_eff;

   assign req = bus_i.read | bus_i.write;
   // The answer comes one cycle after the request is seen.
   assign waitrequest_o = req & ~s.ack;
   assign wr = s.ack & bus_i.write;
   assign lane0 = bus_i.byteenable[0];
   assign data_off = bus_i.address - adc_single_pkg::BA_DATA0;
   assign data_hit = (bus_i.address >= adc_single_pkg::BA_DATA0) &&
      (data_off[adc_single_pkg::DATA_STRIDE_SH-1:0] == '0) &&
      (data_off[31:adc_single_pkg::DATA_STRIDE_SH] < NUM_CH);
   assign data_idx = data_off[adc_single_pkg::DATA_STRIDE_SH +: 4];
   assign busy = (s.st != adc_single_pkg::ST_IDLE);

   always_comb begin
      sim0_rd = s.sim0 & adc_single_pkg::SIM0_WMASK;
      sim0_rd[adc_single_pkg::POS_DONE] = ~busy;
   end

   // ****************************************************************
   // Start source selection
   // ****************************************************************
   // A write that sets the source and the start bit together uses the
   // newly written source, so one write can arm and fire.
   assign sim0_now = (wr && lane0 &&
      bus_i.address == adc_single_pkg::BA_SIM0) ?
      bus_i.writedata[7:0] : s.sim0;
   assign cmp_now = s.sim1[adc_single_pkg::POS_OPMODE];

   assign sw_start = wr && lane0 &&
      bus_i.address == adc_single_pkg::BA_SIM0 &&
      bus_i.writedata[adc_single_pkg::POS_START];
   assign sw_stop = wr && lane0 &&
      bus_i.address == adc_single_pkg::BA_SIM0 &&
      bus_i.writedata[adc_single_pkg::POS_STOP];
   assign sar_start = wr && lane0 &&
      bus_i.address == adc_single_pkg::BA_SAR && cmp_now && scan_active_i;

   always_comb begin
      case (adc_single_pkg::trg_t'({s.sim0[adc_single_pkg::POS_TRG_HI],
            s.sim0[adc_single_pkg::POS_TRG_LO]}))
         adc_single_pkg::TRG_IN2: hw_evt = trig_i.in_bus2;
         adc_single_pkg::TRG_IN3: hw_evt = trig_i.in_bus3;
         adc_single_pkg::TRG_OUT3: hw_evt = trig_i.out_bus3;
         adc_single_pkg::TRG_TMR: hw_evt = trig_i.timer_edge;
         default: hw_evt = 1'b0;
      endcase
   end

   assign start_req =
      (sw_start && (!sim0_now[adc_single_pkg::POS_SSEL] || cmp_now)) ||
      (s.sim0[adc_single_pkg::POS_SSEL] && !cmp_now && hw_evt) ||
      sar_start;
   assign stop_eff = sw_stop && busy;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_s = s;
      next_s.ack = req & ~s.ack;
      next_s.conv.start = 1'b0;
      next_s.conv.abort = 1'b0;
      next_s.irq = 1'b0;
      next_s.dma = 1'b0;

      if (req && !s.ack) begin
         next_s.rdata = '0;
         if (bus_i.address == adc_single_pkg::BA_SIM0) begin
            next_s.rdata[7:0] = sim0_rd;
         end else if (bus_i.address == adc_single_pkg::BA_SIM1) begin
            next_s.rdata[7:0] = s.sim1;
         end else if (bus_i.address == adc_single_pkg::BA_SCM0) begin
            next_s.rdata[7:0] = s.scm0 & adc_single_pkg::SCM0_WMASK;
            next_s.rdata[adc_single_pkg::POS_DONE] = ~scan_active_i;
         end else if (bus_i.address == adc_single_pkg::BA_CVSC) begin
            next_s.rdata[adc_single_pkg::POS_GSPD] = s.gspd;
         end else if (bus_i.address == adc_single_pkg::BA_SAR) begin
            next_s.rdata[RES_W-1:0] = s.sar;
         end else if (bus_i.address == adc_single_pkg::BA_CMP) begin
            next_s.rdata[RES_W-1:0] = s.cmp_result;
         end else if (data_hit) begin
            next_s.rdata[RES_W-1:0] = s.result[data_idx];
         end
      end

      if (wr && lane0) begin
         if (bus_i.address == adc_single_pkg::BA_SIM0) begin
            next_s.sim0 = bus_i.writedata[7:0] & adc_single_pkg::SIM0_WMASK;
         end else if (bus_i.address == adc_single_pkg::BA_SIM1) begin
            next_s.sim1 = bus_i.writedata[7:0];
         end else if (bus_i.address == adc_single_pkg::BA_SCM0) begin
            next_s.scm0 = bus_i.writedata[7:0] & adc_single_pkg::SCM0_WMASK;
         end else if (bus_i.address == adc_single_pkg::BA_CVSC) begin
            next_s.gspd = bus_i.writedata[adc_single_pkg::POS_GSPD];
         end else if (bus_i.address == adc_single_pkg::BA_SAR) begin
            next_s.sar = bus_i.writedata[RES_W-1:0];
         end
      end

      case (s.st)
         adc_single_pkg::ST_IDLE: begin
            if (start_req && !sw_stop) begin
               next_s.conv.start = 1'b1;
               next_s.st = scan_active_i ? adc_single_pkg::ST_FORCED :
                  adc_single_pkg::ST_SINGLE;
            end
         end
         adc_single_pkg::ST_SINGLE, adc_single_pkg::ST_FORCED: begin
            if (stop_eff) begin
               next_s.conv.abort = 1'b1;
               next_s.sar = conv_sar_i;
               next_s.st = adc_single_pkg::ST_IDLE;
            end else if (start_req) begin
               next_s.conv.abort = 1'b1;
               next_s.conv.start = 1'b1;
            end else if (conv_done_i) begin
               if (s.conv.cmp_mode) begin
                  next_s.cmp_result = conv_result_i;
               end else begin
                  next_s.result[s.conv.channel] = conv_result_i;
               end
               next_s.sar = conv_result_i;
               next_s.irq = ~s.sim0[adc_single_pkg::POS_REQ];
               next_s.dma = s.sim0[adc_single_pkg::POS_REQ];
               next_s.st = adc_single_pkg::ST_IDLE;
            end
         end
         default: next_s.st = adc_single_pkg::ST_IDLE;
      endcase

      // The converter command is latched at each start so that a later
      // register write cannot disturb a conversion in flight.
      if (next_s.conv.start) begin
         next_s.conv.cmp_mode = cmp_now;
         next_s.conv.channel = s.sim1[3:0];
         next_s.conv.speed.global_speed_ctrl_bit = s.gspd;
         next_s.conv.speed.double_speed = s.sim1[adc_single_pkg::POS_SPD];
         next_s.conv.speed.sample_hold_en =
            s.sim1[adc_single_pkg::POS_SH_EN] & ~cmp_now;
         next_s.conv.speed.sample_hold_fast =
            s.sim1[adc_single_pkg::POS_SH_SPD] &
            s.sim1[adc_single_pkg::POS_SH_EN] & ~cmp_now;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign readdata_o = s.rdata;
   assign conv_o = s.conv;
   assign scan_hold_o = (s.st == adc_single_pkg::ST_FORCED);
   assign irq_req_o = s.irq;
   assign dma_req_o = s.dma;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   sequence idle_hw_fire;
      !busy && s.sim0[adc_single_pkg::POS_SSEL] && !cmp_now && hw_evt &&
         !sw_stop;
   endsequence
   sequence run_stop;
      busy && stop_eff;
   endsequence

   trig_mux_a: assert property (idle_hw_fire |=> conv_o.start)
      else $error("Selected hardware trigger did not start");
   sw_ignore_a: assert property (!busy && !sim0_now[adc_single_pkg::POS_SSEL]
      && !sw_start && !sar_start |=> !conv_o.start)
      else $error("Start without software write");
   cmp_hw_a: assert property (!busy && cmp_now && !sw_start && !sar_start
      |=> !conv_o.start)
      else $error("Comparator started by hardware trigger");
   req_route_a: assert property (busy && conv_done_i && !sw_stop &&
      !start_req |=> irq_req_o == !$past(s.sim0[adc_single_pkg::POS_REQ])
      && dma_req_o == $past(s.sim0[adc_single_pkg::POS_REQ]))
      else $error("Completion request routed wrong");
   done_low_a: assert property (conv_o.start |->
      !sim0_rd[adc_single_pkg::POS_DONE])
      else $error("Done flag high while running");
   stop_halt_a: assert property (run_stop |=> !busy && conv_o.abort &&
      !conv_o.start)
      else $error("Stop did not halt operation");
   sar_keep_a: assert property (run_stop |=> s.sar == $past(conv_sar_i) &&
      s.result == $past(s.result))
      else $error("Stop lost partial value or stored result");
   stop_prio_a: assert property (!busy && sw_start && sw_stop
      |=> !conv_o.start ##1 !busy)
      else $error("Start acted despite stop");
   forced_end_a: assert property (s.st == adc_single_pkg::ST_FORCED &&
      stop_eff |=> !scan_hold_o)
      else $error("Scan hold kept after stop");
   restart_a: assert property (busy && start_req && !sw_stop
      |=> conv_o.abort && conv_o.start && busy)
      else $error("Restart did not abort and start");
   rd_zero_a: assert property (s.ack && bus_i.read &&
      bus_i.address == adc_single_pkg::BA_SIM0 |-> readdata_o[1:0] == 2'h0)
      else $error("Command bits read nonzero");
   req_pulse_a: assert property ($rose(irq_req_o || dma_req_o)
      |=> !irq_req_o && !dma_req_o)
      else $error("Completion request longer than one cycle");
   bus_ans_a: assert property (req |-> ##[0:1] !waitrequest_o)
      else $error("Bus answer late");

endmodule

// ---- logic/adc_single_pkg.sv ----
package adc_single_pkg;

   // ****************************************************************
   // Register indices and bus addresses
   // ****************************************************************
   localparam logic [31:0] IDX_SIM0 = 32'h0080_0080;
   localparam logic [31:0] IDX_SIM1 = 32'h0080_0081;
   localparam logic [31:0] IDX_SCM0 = 32'h0080_0084;
   localparam logic [31:0] IDX_CVSC = 32'h0080_0087;
   localparam logic [31:0] IDX_SAR = 32'h0080_0088;
   localparam logic [31:0] IDX_CMP = 32'h0080_008C;
   localparam logic [31:0] IDX_DATA0 = 32'h0080_0090;
   localparam logic [31:0] BA_SIM0 = IDX_SIM0 << 2;
   localparam logic [31:0] BA_SIM1 = IDX_SIM1 << 2;
   localparam logic [31:0] BA_SCM0 = IDX_SCM0 << 2;
   localparam logic [31:0] BA_CVSC = IDX_CVSC << 2;
   localparam logic [31:0] BA_SAR = IDX_SAR << 2;
   localparam logic [31:0] BA_CMP = IDX_CMP << 2;
   localparam logic [31:0] BA_DATA0 = IDX_DATA0 << 2;
   // Data registers sit every second index, so eight bytes apart.
   localparam int DATA_STRIDE_SH = 3;

   // ****************************************************************
   // Field positions (b0 of the byte is its most significant bit)
   // ****************************************************************
   localparam int POS_TRG_HI = 7;
   localparam int POS_TRG_LO = 5;
   localparam int POS_SSEL = 4;
   localparam int POS_REQ = 3;
   localparam int POS_DONE = 2;
   localparam int POS_STOP = 1;
   localparam int POS_START = 0;
   localparam int POS_OPMODE = 7;
   localparam int POS_SPD = 6;
   localparam int POS_SH_EN = 5;
   localparam int POS_SH_SPD = 4;
   localparam int POS_GSPD = 0;
   localparam logic [7:0] SIM0_WMASK = 8'hB8;
   localparam logic [7:0] SCM0_WMASK = 8'hF8;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_FORCED} mode_st_t;
   typedef enum logic [1:0] {TRG_IN2, TRG_IN3, TRG_OUT3, TRG_TMR} trg_t;

   typedef struct packed {
      logic [31:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_t;

   typedef struct packed {
      logic in_bus2;
      logic in_bus3;
      logic out_bus3;
      logic timer_edge;
   } trig_evt_t;

   typedef struct packed {
      logic global_speed_ctrl_bit;
      logic double_speed;
      logic sample_hold_en;
      logic sample_hold_fast;
   } speed_t;

   typedef struct packed {
      logic start;
      logic abort;
      logic cmp_mode;
      logic [3:0] channel;
      speed_t speed;
   } conv_cmd_t;

endpackage

// ---- bench/conv_core_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Converter core stand-in
// ****************************************************************
module conv_core_model (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire adc_single_pkg::conv_cmd_t cmd_i,
   input wire logic [9:0] res_i,
   input wire logic [7:0] lat_i,
   output logic done_o,
   output logic [9:0] result_o,
   output logic [9:0] sar_o
);
   logic busy;
   logic [7:0] cnt;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         done_o <= 1'b0;
         sar_o <= 10'h000;
      end else begin
         done_o <= 1'b0;
         // A start beats an abort, so a restart runs the full length again.
         if (cmd_i.start) begin
            busy <= 1'b1;
            cnt <= lat_i;
         end else if (cmd_i.abort) begin
            busy <= 1'b0;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            done_o <= 1'b1;
            sar_o <= res_i;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
            sar_o <= sar_o ^ {2'h0, cnt};
         end
      end
   end
   // Outside its one valid cycle the result bus carries a changing pattern.
   assign result_o = done_o ? res_i : ~sar_o;
endmodule

// ---- bench/test_adc_single_ctrl.sv ----
`timescale 1ns/10ps
module test_adc_single_ctrl;
   localparam logic [31:0] A0 = adc_single_pkg::BA_SIM0;
   localparam logic [31:0] A1 = adc_single_pkg::BA_SIM1;
   localparam logic [31:0] AD = adc_single_pkg::BA_DATA0;
   localparam logic [31:0] ACMP = adc_single_pkg::BA_CMP;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   adc_single_pkg::av_req_t bus = '0;
   adc_single_pkg::trig_evt_t trig = '0;
   adc_single_pkg::conv_cmd_t conv;
   logic [31:0] rdata;
   logic wreq, done, irq, dma, hold;
   logic scan = 1'b0;
   logic hold_q = 1'b0;
   logic gspd = 1'b0;
   logic [9:0] res = 10'h000;
   logic [9:0] cres, sar, r;
   logic [9:0] dreg [16];
   logic [7:0] lat = 8'h14;
   logic [7:0] k;
   logic [35:0] q [$];
   int errors = 0;
   int n_checks = 0;
   int seed = 82351;
   int c;

   adc_single_ctrl adc_single_ctrl_i (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .bus_i(bus), .readdata_o(rdata),
      .waitrequest_o(wreq), .trig_i(trig), .scan_active_i(scan),
      .conv_done_i(done), .conv_result_i(cres), .conv_sar_i(sar),
      .conv_o(conv), .scan_hold_o(hold), .irq_req_o(irq),
      .dma_req_o(dma));
   conv_core_model conv_core_model_i (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .cmd_i(conv), .res_i(res), .lat_i(lat),
      .done_o(done), .result_o(cres), .sar_o(sar));

   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // ****************************************************************
   // Notes, comparison and the end of the run
   // ****************************************************************
   task conclude;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task note(input logic [3:0] kd, input logic [31:0] v);
      q.push_back({kd, v});
   endtask

   // An event with no note is matched against all ones and so fails.
   task cmp(input logic [35:0] got);
      logic [35:0] e;
      n_checks++;
      e = (q.size() > 0) ? q.pop_front() : '1;
      if (got !== e) begin
         errors++;
         $display("wrong value at %0t got %h expected %h", $time, got, e);
      end
   endtask

   always @(posedge clk_sys_i) begin
      if (resetn_i === 1'b1) begin
         if (conv.abort !== 1'b0) cmp({4'h2, 32'h0});
         if (conv.start !== 1'b0) cmp({4'h1, 23'h0, conv.cmp_mode,
            conv.channel, conv.speed});
         if (irq !== 1'b0) cmp({4'h3, 32'h0});
         if (dma !== 1'b0) cmp({4'h4, 32'h0});
         if (hold !== hold_q) cmp({4'h5, 31'h0, hold});
         hold_q <= hold;
         if (bus.read && wreq === 1'b0) cmp({4'h0, rdata});
      end
   end

   // ****************************************************************
   // Bus master and stimulus helpers
   // ****************************************************************
   task acc(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys_i);
      bus <= '{address: a, read: !w, write: w, writedata: d,
         byteenable: 4'hF};
      do @(posedge clk_sys_i); while (wreq !== 1'b0);
      bus.read <= 1'b0;
      bus.write <= 1'b0;
   endtask

   task rd(input logic [31:0] a, input logic [31:0] e);
      note(4'h0, e);
      acc(a, 1'b0, 32'h0);
   endtask

   task drain;
      for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk_sys_i);
      if (q.size() > 0) cmp('1);
      q.delete();
      repeat (3) @(posedge clk_sys_i);
   endtask

   task pulse(input logic [3:0] t);
      @(posedge clk_sys_i);
      trig <= t;
      @(posedge clk_sys_i);
      trig <= '0;
   endtask

   function automatic logic [31:0] s0(input logic [7:0] w, input logic d);
      return {24'h0, (w & adc_single_pkg::SIM0_WMASK) | {5'h0, d, 2'h0}};
   endfunction

   task nst(input logic [7:0] cfg);
      note(4'h1, {23'h0, cfg[7], cfg[3:0], gspd, cfg[6],
         cfg[5] & ~cfg[7], cfg[4] & cfg[5] & ~cfg[7]});
   endtask

   // One whole operation: configure, start, wait for completion, check.
   task run(input logic [7:0] cfg, input logic [7:0] ctl);
      r = 10'($random(seed));
      res <= r;
      acc(A1, 1'b1, {24'h0, cfg});
      nst(cfg);
      acc(A0, 1'b1, {24'h0, ctl});
      if (lat > 8'h08) rd(A0, s0(ctl, 1'b0));
      note(ctl[3] ? 4'h4 : 4'h3, 32'h0);
      drain;
      rd(A0, s0(ctl, 1'b1));
      if (cfg[7]) rd(ACMP, {22'h0, r});
      else dreg[cfg[3:0]] = r;
      rd(AD + ({28'h0, cfg[3:0]} << 3), {22'h0, dreg[cfg[3:0]]});
   endtask

   initial begin
      #100000;
      errors++;
      conclude();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (8) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      rd(A0, 32'h04);
      rd(A1, 32'h00);
      acc(A0 + 32'h8, 1'b1, 32'hFF);
      rd(A0 + 32'h8, 32'h0);
      for (c = 0; c < 3; c++) begin
         k = 8'($random(seed));
         acc(A1, 1'b1, {24'h0, k});
         rd(A1, {24'h0, k});
      end
      acc(adc_single_pkg::BA_CVSC, 1'b1, 32'h1);
      gspd = 1'b1;
      run(8'h35, 8'h01);
      run(8'h5A, 8'h09);
      run(8'hF3, 8'h01);
      lat <= 8'h03;
      run(8'h05, 8'h01);
      lat <= 8'h14;
      nst(8'h05);
      acc(A0, 1'b1, 32'h01);
      note(4'h2, 32'h0);
      acc(A0, 1'b1, 32'h02);
      rd(A0, 32'h04);
      rd(AD + 32'h28, {22'h0, dreg[5]});
      drain;
      nst(8'h05);
      acc(A0, 1'b1, 32'h01);
      note(4'h2, 32'h0);
      acc(A0, 1'b1, 32'h03);
      rd(A0, 32'h04);
      drain;
      acc(A0, 1'b1, 32'h02);
      acc(A0, 1'b1, 32'h03);
      acc(A0, 1'b1, 32'h00);
      drain;
      nst(8'h05);
      acc(A0, 1'b1, 32'h01);
      note(4'h2, 32'h0);
      nst(8'h05);
      acc(A0, 1'b1, 32'h01);
      note(4'h3, 32'h0);
      drain;
      for (c = 0; c < 4; c++) begin
         k = {c[1], 1'b0, c[0], 5'h10};
         acc(A0, 1'b1, {24'h0, k});
         acc(A0, 1'b1, {24'h0, k | 8'h01});
         pulse(~(4'h8 >> c));
         nst(8'h05);
         pulse(4'h8 >> c);
         note(4'h3, 32'h0);
         drain;
      end
      acc(A0, 1'b1, 32'hA0);
      pulse(4'hF);
      drain;
      acc(A1, 1'b1, 32'h85);
      acc(A0, 1'b1, 32'h10);
      pulse(4'h8);
      drain;
      run(8'h85, 8'h11);
      scan <= 1'b1;
      acc(A1, 1'b1, 32'h02);
      nst(8'h02);
      note(4'h5, 32'h1);
      acc(A0, 1'b1, 32'h01);
      note(4'h2, 32'h0);
      note(4'h5, 32'h0);
      acc(A0, 1'b1, 32'h02);
      drain;
      nst(8'h02);
      note(4'h5, 32'h1);
      acc(A0, 1'b1, 32'h01);
      note(4'h3, 32'h0);
      note(4'h5, 32'h0);
      drain;
      acc(A1, 1'b1, 32'h83);
      nst(8'h83);
      note(4'h5, 32'h1);
      acc(adc_single_pkg::BA_SAR, 1'b1, 32'h155);
      note(4'h3, 32'h0);
      note(4'h5, 32'h0);
      drain;
      scan <= 1'b0;
      conclude();
   end
endmodule
